//--- hdl/adc_seq_pkg.sv
// Shared constants and types for the converter bus interface
package adc_seq_pkg;

	// Bus pins as seen by the device
	typedef struct packed {
		logic phase_clk;
		logic read_not_write;
		logic chip_select_n;
		logic register_select;
		logic reset_n;
	} bus_pins_t;

	typedef enum logic {
		PTR_UPPER = 1'b0,
		PTR_LOWER = 1'b1
	} byte_ptr_t;

	localparam int DATA_W     = 8;
	localparam int CHAN_W     = 4;
	localparam int PORT_W     = 6;
	localparam int CYC_W      = 6;
	localparam int SYNC_W     = 20;

	// Register select codes
	localparam logic RS_CONTROL = 1'b1;
	localparam logic RS_RESULT  = 1'b0;
	localparam logic RS_STATUS  = 1'b1;

	// Field positions
	localparam int START_POS  = 8;
	localparam int DONE_POS   = 15;
	localparam int PORT_LSB   = 8;
	localparam int CHAN_LSB   = 0;

	// Reset values
	localparam logic [CHAN_W-1:0] CHAN_RST   = 4'h0;
	localparam logic [15:0]       RESULT_RST = 16'h0000;

	// Conversion timing, in bus clock cycles after the start write
	localparam logic [CYC_W-1:0] CYC_FIRST   = 6'h01;
	localparam logic [CYC_W-1:0] CYC_SAMPLE  = 6'h0c;
	localparam logic [CYC_W-1:0] CYC_CONVERT = 6'h0d;
	localparam logic [CYC_W-1:0] CYC_STEP0   = 6'h0e;
	localparam logic [CYC_W-1:0] CYC_STEPN   = 6'h1c;
	localparam logic [CYC_W-1:0] CYC_LATCH   = 6'h20;

endpackage

//--- hdl/sync2.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // sync2

//--- hdl/sar_engine.sv
// Successive-approximation register, one bit decided per step
`timescale 1ns/1ps
module sar_engine #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Control
	input  wire logic             start,
	input  wire logic             step,
	input  wire logic             comp_high,
	// Trial code, also the final result
	output logic      [WIDTH-1:0] trial_q
);

	logic [WIDTH-1:0] mask_q;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			trial_q <= '0;
			mask_q  <= '0;
		end
		else if (start)
		begin
			trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
			mask_q  <= {1'b1, {(WIDTH-1){1'b0}}};
		end
		else if (step && mask_q != '0)
		begin
			// Drop the trial bit when the input lies below the trial level
			trial_q <= (comp_high ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);
			mask_q  <= mask_q >> 1;
		end
	end

endmodule // sar_engine

//--- hdl/adc_bus_interface_sequencer.sv
// Bus interface and conversion sequencer of the 8-bit converter
//
// Summary of operation
// - Three 16-bit registers, upper and lower bytes
// - Pointer upper first, then lower while selected
// - Pointer returns upper after one deselected cycle
// - Single-byte access reaches only upper byte
// - Select-high write loads control; otherwise ignored
// - Read: select low result, high status
// - Four-bit channel code drives input multiplexer
// - Unused control bits have no effect
// - Channel changes only on 16-bit write or reset pin
// - Start bit begins conversion after write
// - Control write spans two bus cycles
// - Sample selected input for 12.5 cycles
// - Cycle 13 disconnects input, starts approximation
// - Cycle 32 rising edge latches result, done
// - Result in lower byte, MSB at bit 7
// - Any control write clears done flag
// - Other upper result bits read zero
// - Reads allowed mid-conversion, old result shown
// - Status shows channel and port bits, zeros elsewhere
// - Port bits always show pin levels
// - Reset pin clears start, done, channel, pointer
// - Data drivers off unless reading, and in reset
`timescale 1ns/1ps
module adc_bus_interface_sequencer (
	// Clock and reset
	input  wire logic                             mclk,
	input  wire logic                             rst,
	// Processor bus
	input  wire adc_seq_pkg::bus_pins_t           bus_pins,
	input  wire logic [adc_seq_pkg::DATA_W-1:0]   data_in,
	output logic      [adc_seq_pkg::DATA_W-1:0]   data_out,
	output logic                                  data_oe_n,
	// Shared digital port and comparator
	input  wire logic [adc_seq_pkg::PORT_W-1:0]   shared_port_bits,
	input  wire logic                             comparator_high,
	// Analog front end control
	output logic      [adc_seq_pkg::CHAN_W-1:0]   channel_select_field,
	output logic                                  sample_connect,
	output logic                                  converting,
	output logic      [adc_seq_pkg::DATA_W-1:0]   dac_code
);
	import adc_seq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	logic [SYNC_W-1:0] pins_s;
	logic              phase_s;
	logic              rnw_s;
	logic              cs_n_s;
	logic              rs_s;
	logic              reset_n_s;
	logic [DATA_W-1:0] din_s;
	logic [PORT_W-1:0] port_s;
	logic              comp_s;

	sync2 #(.WIDTH(SYNC_W)) u_sync (
		.mclk     (mclk),
		.rst      (rst),
		.async_in ({bus_pins, data_in, shared_port_bits, comparator_high}),
		.sync_out (pins_s)
	);

	assign {phase_s, rnw_s, cs_n_s, rs_s, reset_n_s, din_s, port_s, comp_s} = pins_s;

	logic phase_prev_q;
	logic phase_rise;
	logic phase_fall;
	logic selected;
	logic dev_reset;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			phase_prev_q <= 1'b0;
		else
			phase_prev_q <= phase_s;
	end

	assign phase_rise = phase_s & ~phase_prev_q;
	assign phase_fall = ~phase_s & phase_prev_q;
	assign selected   = ~cs_n_s;
	assign dev_reset  = ~reset_n_s;

	////////////////////////////////////////////////////////////////////////
	// Byte pointer
	byte_ptr_t ptr_q;

	// Bytes have no address of their own; the pointer picks them
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ptr_q <= PTR_UPPER;
		else if (dev_reset)
			ptr_q <= PTR_UPPER;
		else if (phase_fall)
			ptr_q <= selected ? PTR_LOWER : PTR_UPPER;
	end

	////////////////////////////////////////////////////////////////////////
	// Control register
	logic              wr_ctrl;
	logic              wr_upper;
	logic              wr_lower;
	logic [CHAN_W-1:0] channel_q;
	logic              start_bit_q;
	logic              start_pend_q;
	logic              launch;

	// A write with register select low falls through: no response
	assign wr_ctrl  = phase_fall & selected & ~rnw_s & (rs_s == RS_CONTROL) & ~dev_reset;
	assign wr_upper = wr_ctrl & (ptr_q == PTR_UPPER);
	assign wr_lower = wr_ctrl & (ptr_q == PTR_LOWER);
	// The cycle after the upper byte always closes the write
	assign launch   = phase_fall & start_pend_q & ~dev_reset;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			channel_q <= CHAN_RST;
		else if (dev_reset)
			channel_q <= CHAN_RST;
		else if (wr_lower)
			channel_q <= din_s[CHAN_LSB +: CHAN_W];
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			start_bit_q <= 1'b0;
		else if (dev_reset)
			start_bit_q <= 1'b0;
		else if (wr_upper)
			start_bit_q <= din_s[START_POS - DATA_W];
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			start_pend_q <= 1'b0;
		else if (dev_reset || launch)
			start_pend_q <= 1'b0;
		else if (wr_upper)
			start_pend_q <= din_s[START_POS - DATA_W];
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequence
	logic [CYC_W-1:0] cyc_q;
	logic             sar_start;
	logic             sar_step;
	logic             latch_now;
	logic [DATA_W-1:0] sar_code;

	// Counts on the bus clock only; a stopped clock stalls the sample
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cyc_q <= '0;
		else if (dev_reset)
			cyc_q <= '0;
		else if (launch)
			cyc_q <= CYC_FIRST;
		else if (latch_now)
			cyc_q <= '0;
		else if (phase_fall && cyc_q != '0 && cyc_q < CYC_LATCH)
			cyc_q <= cyc_q + CYC_FIRST;
	end

	assign sar_start = phase_fall & (cyc_q == CYC_SAMPLE) & ~dev_reset;
	assign sar_step  = phase_fall & ~cyc_q[0] & (cyc_q >= CYC_STEP0) & (cyc_q <= CYC_STEPN);
	assign latch_now = phase_rise & (cyc_q == CYC_LATCH) & ~dev_reset;

	sar_engine #(.WIDTH(DATA_W)) u_sar (
		.mclk      (mclk),
		.rst       (rst),
		.start     (sar_start),
		.step      (sar_step),
		.comp_high (comp_s),
		.trial_q   (sar_code)
	);

	logic sample_q;
	logic conv_q;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sample_q <= 1'b0;
			conv_q   <= 1'b0;
		end
		else
		begin
			// Half a cycle into cycle 13 the hold element is let go
			sample_q <= (cyc_q != '0 && cyc_q <= CYC_SAMPLE)
				|| (cyc_q == CYC_CONVERT && !phase_s);
			conv_q   <= cyc_q >= CYC_CONVERT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result register and done flag
	logic [DATA_W-1:0] result_q;
	logic              done_q;

	// Reset pin leaves the stored result alone
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			result_q <= RESULT_RST[DATA_W-1:0];
		else if (latch_now)
			result_q <= sar_code;
	end

	// Setting wins over a clear in the same cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			done_q <= 1'b0;
		else if (dev_reset)
			done_q <= 1'b0;
		else if (latch_now)
			done_q <= 1'b1;
		else if (wr_ctrl)
			done_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	logic        rd_active;
	logic [15:0] rd_word;
	logic [15:0] result_word;
	logic [15:0] status_word;
	logic [DATA_W-1:0] data_out_q;
	logic        data_oe_n_q;

	always_comb
	begin
		result_word = '0;
		result_word[DATA_W-1:0] = result_q;
		result_word[DONE_POS] = done_q;
		status_word = '0;
		status_word[CHAN_LSB +: CHAN_W] = channel_q;
		status_word[PORT_LSB +: PORT_W] = port_s;
	end

	assign rd_active = phase_s & selected & rnw_s & ~dev_reset;
	assign rd_word   = (rs_s == RS_STATUS) ? status_word : result_word;

	// Drivers stay off outside a read so the bus is never fought
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			data_out_q  <= '0;
			data_oe_n_q <= 1'b1;
		end
		else
		begin
			data_oe_n_q <= ~rd_active;
			if (!rd_active)
				data_out_q <= '0;
			else if (ptr_q == PTR_UPPER)
				data_out_q <= rd_word[15:8];
			else
				data_out_q <= rd_word[7:0];
		end
	end

	assign data_out             = data_out_q;
	assign data_oe_n            = data_oe_n_q;
	assign channel_select_field = channel_q;
	assign sample_connect       = sample_q;
	assign converting           = conv_q;
	assign dac_code             = sar_code;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_ctrl_upper_start;
		wr_upper && din_s[START_POS - DATA_W];
	endsequence

	// One E period is far inside the bound; a stopped E leaves these vacuous
	sequence s_next_fall;
		first_match(##[0:1000] phase_fall);
	endsequence

	sequence s_next_rise;
		first_match(##[0:1000] phase_rise);
	endsequence

	a_ptr_to_lower: assert property (@(posedge mclk) disable iff (rst)
		phase_fall && selected && !dev_reset |=> ptr_q == PTR_LOWER)
		else $error("pointer did not move to lower byte");

	a_ptr_to_upper: assert property (@(posedge mclk) disable iff (rst)
		phase_fall && !selected |=> ptr_q == PTR_UPPER)
		else $error("pointer did not return to upper byte");

	a_ignored_write: assert property (@(posedge mclk) disable iff (rst)
		phase_fall && selected && !rnw_s && rs_s != RS_CONTROL && !dev_reset
		|=> $stable(channel_q) && $stable(done_q))
		else $error("write with select low changed state");

	a_upper_no_chan: assert property (@(posedge mclk) disable iff (rst)
		wr_upper |=> $stable(channel_q))
		else $error("single-byte write changed channel");

	a_start_launch: assert property (@(posedge mclk) disable iff (rst || dev_reset)
		s_ctrl_upper_start ##1 s_next_fall |=> cyc_q == CYC_FIRST)
		else $error("conversion did not start after control write");

	a_done_clear: assert property (@(posedge mclk) disable iff (rst)
		wr_ctrl && !latch_now && !dev_reset |=> !done_q)
		else $error("control write left done flag set");

	a_latch_done: assert property (@(posedge mclk) disable iff (rst)
		latch_now |=> done_q && result_q == $past(sar_code) && cyc_q == '0)
		else $error("result not latched at cycle 32");

	a_sample_phase: assert property (@(posedge mclk) disable iff (rst)
		cyc_q == CYC_FIRST |=> sample_q && !conv_q)
		else $error("input not sampled after start");

	// The hold element lets go at the rising E half way into cycle 13
	a_hold_release: assert property (@(posedge mclk) disable iff (rst || dev_reset)
		sar_start ##1 s_next_rise |=> conv_q && !sample_q)
		else $error("input not released at cycle 13");

	a_reset_state: assert property (@(posedge mclk) disable iff (rst)
		dev_reset |=> !done_q && !start_bit_q && channel_q == CHAN_RST
			&& ptr_q == PTR_UPPER && $stable(result_q) ##1 data_oe_n_q)
		else $error("reset pin state wrong");

	a_result_upper: assert property (@(posedge mclk) disable iff (rst)
		rd_active && rs_s == RS_RESULT && ptr_q == PTR_UPPER
		|=> data_out_q == {$past(done_q), 7'h00})
		else $error("result upper byte not zero");

endmodule // adc_bus_interface_sequencer

//--- sim/bus_host_model.sv
// Processor bus model: phase clock, strobes, data bus and reset pin
`timescale 1ns/1ps
module bus_host_model (
	// Clock
	input  wire logic                           mclk,
	// Device bus
	output adc_seq_pkg::bus_pins_t              bus_pins,
	output logic      [adc_seq_pkg::DATA_W-1:0] data_in,
	input  wire logic [adc_seq_pkg::DATA_W-1:0] data_out,
	input  wire logic                           data_oe_n
);
	import adc_seq_pkg::*;
	logic [3:0] ph_q = 4'h0;
	logic       rnw_q = 1'b1;
	logic       cs_n_q = 1'b1;
	logic       rs_q = 1'b0;
	logic       pin_rst_n_q = 1'b1;
	initial data_in = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// Phase clock never pauses, so a started conversion can finish
	always @(negedge mclk)
		ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
	assign bus_pins = {ph_q < 4'h6, rnw_q, cs_n_q, rs_q, pin_rst_n_q};
	////////////////////////////////////////////////////////////////////////
	// One E cycle; pins change before E rises and hold well past the fall
	task automatic cycle(input logic cs_n, input logic rnw, input logic rs,
		input logic [7:0] wd, output logic [7:0] rd, output logic oe_n);
		do @(posedge mclk); while (ph_q != 4'ha);
		@(negedge mclk);
		cs_n_q = cs_n;
		rnw_q = rnw;
		rs_q = rs;
		// A released bus shows the inverse of its last value
		data_in = (cs_n | rnw) ? ~data_in : wd;
		do @(posedge mclk); while (ph_q != 4'h5);
		rd = data_out;
		oe_n = data_oe_n;
	endtask
	// Reset pin low for two whole E cycles
	task automatic pin_reset();
		@(negedge mclk);
		pin_rst_n_q = 1'b0;
		repeat (24) @(negedge mclk);
		pin_rst_n_q = 1'b1;
	endtask
endmodule // bus_host_model

//--- sim/tb_adc_bus_interface_sequencer.sv
// Self-checking bench for the converter bus interface and sequencer
`timescale 1ns/1ps
module tb_adc_bus_interface_sequencer;
	import adc_seq_pkg::*;
	typedef struct packed {
		logic [3:0]  ch;
		logic [7:0]  v;
		logic [5:0]  port;
		logic [15:0] res;
		logic [15:0] stat;
	} row_t;
	logic              mclk = 1'b0;
	logic              rst = 1'b1;
	bus_pins_t         bus_pins;
	logic [DATA_W-1:0] data_in;
	logic [DATA_W-1:0] data_out;
	logic              data_oe_n;
	logic [PORT_W-1:0] port_q = 6'h00;
	logic [7:0]        vin_q = 8'h00;
	logic              comparator_high;
	logic [CHAN_W-1:0] channel_select_field;
	logic              sample_connect;
	logic              converting;
	logic [DATA_W-1:0] dac_code;
	logic [15:0]       rd;
	logic [1:0]        oe;
	logic [7:0]        b;
	logic              o;
	int                num_errors = 0;
	int                check_count = 0;
	int                cyc_count = 0;
	row_t              rows [6] = '{
		'{4'h0, 8'hff, 6'h2a, 16'h80ff, 16'h2a00},
		'{4'h1, 8'h00, 6'h15, 16'h8000, 16'h1501},
		'{4'h5, 8'h80, 6'h3f, 16'h8080, 16'h3f05},
		'{4'hb, 8'h7f, 6'h00, 16'h807f, 16'h000b},
		'{4'h6, 8'h5a, 6'h01, 16'h805a, 16'h0106},
		'{4'hf, 8'ha5, 6'h20, 16'h80a5, 16'h200f}};
	initial
		forever #2 mclk = ~mclk;
	// Ideal comparator: input at or above the trial code keeps the bit
	assign comparator_high = (vin_q >= dac_code);
	////////////////////////////////////////////////////////////////////////
	adc_bus_interface_sequencer u_adc_bus_interface_sequencer (
		.mclk(mclk), .rst(rst), .bus_pins(bus_pins), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n),
		.shared_port_bits(port_q), .comparator_high(comparator_high),
		.channel_select_field(channel_select_field),
		.sample_connect(sample_connect), .converting(converting),
		.dac_code(dac_code));
	bus_host_model u_bus_host_model (
		.mclk(mclk), .bus_pins(bus_pins), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n));
	////////////////////////////////////////////////////////////////////////
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t flag %b want %b", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) u_bus_host_model.cycle(1'b1, 1'b1, 1'b0, 8'h00, b, o);
	endtask
	// One or two selected cycles, then one deselected cycle
	task automatic xfer(input logic rnw, input logic rs, input logic [15:0] wd, input int n);
		rd = 16'h0000;
		oe = 2'b11;
		u_bus_host_model.cycle(1'b0, rnw, rs, wd[15:8], rd[15:8], oe[1]);
		if (n == 2)
			u_bus_host_model.cycle(1'b0, rnw, rs, wd[7:0], rd[7:0], oe[0]);
		u_bus_host_model.cycle(1'b1, rnw, rs, 8'h00, b, o);
		chk1(o, 1'b1);
	endtask
	task automatic convert(input row_t r, input logic [7:0] old);
		@(negedge mclk);
		vin_q <= r.v;
		port_q <= r.port;
		xfer(1'b0, RS_CONTROL, {8'hff, 4'hf, r.ch}, 2);
		chk16({14'h0, oe}, 16'h0003);
		chk1(sample_connect, 1'b1);
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, {8'h00, old});
		chk16({14'h0, oe}, 16'h0000);
		idle(12);
		chk1(sample_connect, 1'b0);
		chk1(converting, 1'b1);
		idle(20);
		chk1(converting, 1'b0);
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, r.res);
		xfer(1'b1, RS_STATUS, 16'h0000, 2);
		chk16(rd, r.stat);
		chk16({12'h0, channel_select_field}, {12'h0, r.ch});
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Run takes about 6000 cycles; a hang is cut well beyond that
	always @(posedge mclk)
	begin
		cyc_count++;
		if (cyc_count == 12000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		port_q <= 6'h2d;
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, RESULT_RST);
		for (int c = 0; c < 16; c++)
		begin
			xfer(1'b0, RS_CONTROL, {8'hfe, 4'hf, c[3:0]}, 2);
			xfer(1'b1, RS_STATUS, 16'h0000, 2);
			chk16(rd, {8'h2d, 4'h0, c[3:0]});
		end
		for (int i = 0; i < 6; i++)
			convert(rows[i], (i == 0) ? 8'h00 : rows[i-1].res[7:0]);
		// Write with register select low is dropped
		xfer(1'b0, RS_RESULT, 16'hff03, 2);
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, 16'h80a5);
		// Single-byte write without start: only the done flag drops
		xfer(1'b0, RS_CONTROL, 16'h0003, 1);
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, 16'h00a5);
		chk1(converting, 1'b0);
		// Single-byte start converts on the channel already chosen
		@(negedge mclk);
		vin_q <= 8'h33;
		xfer(1'b0, RS_CONTROL, 16'h0100, 1);
		idle(34);
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, 16'h8033);
		chk16({12'h0, channel_select_field}, 16'h000f);
		// Byte pointer: single byte, held select, then deselect
		xfer(1'b1, RS_STATUS, 16'h0000, 1);
		chk16(rd, 16'h2000);
		u_bus_host_model.cycle(1'b0, 1'b1, RS_RESULT, 8'h00, rd[15:8], o);
		u_bus_host_model.cycle(1'b0, 1'b1, RS_RESULT, 8'h00, rd[7:0], o);
		chk16(rd, 16'h8033);
		u_bus_host_model.cycle(1'b0, 1'b1, RS_RESULT, 8'h00, rd[15:8], o);
		chk16(rd, 16'h3333);
		idle(1);
		xfer(1'b1, RS_RESULT, 16'h0000, 1);
		chk16(rd, 16'h8000);
		// Pin reset mid-conversion keeps the old result
		@(negedge mclk);
		vin_q <= 8'h44;
		xfer(1'b0, RS_CONTROL, 16'h0107, 2);
		idle(5);
		u_bus_host_model.pin_reset();
		idle(30);
		chk1(converting, 1'b0);
		xfer(1'b1, RS_RESULT, 16'h0000, 2);
		chk16(rd, 16'h0033);
		xfer(1'b1, RS_STATUS, 16'h0000, 2);
		chk16(rd, 16'h2000);
		end_of_test();
	end
endmodule // tb_adc_bus_interface_sequencer
